// *** logic/fap_params.svh ***
// constants of the floppy auto powerdown block
`ifndef FAP_PARAMS_SVH
`define FAP_PARAMS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define FAP_IDX_SRA     4'h0
`define FAP_IDX_SRB     4'h1
`define FAP_IDX_DOR     4'h2
`define FAP_IDX_DSR     4'h4
`define FAP_IDX_DATA    4'h5
`define FAP_IDX_DIR     4'h7
`define FAP_IDX_APC     4'h8
`define FAP_IDX_MODE    4'h9
`define FAP_IDX_PSTAT   4'hA

// ==========================================================
// field positions
`define FAP_DOR_DSEL_BIT   0
`define FAP_DOR_NRST_BIT   2
`define FAP_DOR_MOT_LO     4
`define FAP_DOR_MOT_HI     7
`define FAP_DSR_SWRST_BIT  7
`define FAP_DSR_PD_BIT     6
`define FAP_APC_EN_BIT     0
`define FAP_MODE_SHUT_BIT  5

// ==========================================================
// reset values and idle status
`define FAP_DOR_RESET   8'h00
`define FAP_DSR_RESET   8'h02
`define FAP_CCR_RESET   8'h02
`define FAP_APC_RESET   8'h00
`define FAP_MODE_RESET  8'h00
`define FAP_MSR_IDLE    8'h80

// ==========================================================
// timing
`define FAP_CLK_MHZ      125
`define FAP_APD_TIME_MS  10
`define FAP_APD_CYCLES   (`FAP_APD_TIME_MS * 1000 * `FAP_CLK_MHZ)
`define FAP_TMR_W        21

`endif

// *** logic/fap_pkg.sv ***
// types of the floppy auto powerdown block
`include "fap_params.svh"

package fap_pkg;

  // ==========================================================
  // timer state
  typedef struct packed {
    logic [`FAP_TMR_W-1:0] count;
    logic                  expired;
  } fap_tmr_t;

  // ==========================================================
  // controller state
  typedef struct packed {
    logic [7:0] digital_output_reg;
    logic [7:0] dsr;
    logic [7:0] ccr;
    logic [7:0] apc;
    logic [7:0] mode;
    logic       pd;
    logic [7:0] prdata;
    logic       pready;
    logic       pslverr;
    logic       core_reset;
    logic [7:0] data_wr;
    logic       data_wr_stb;
    logic       data_rd_stb;
    logic       boost;
    logic [1:0] motor_n;
    logic [1:0] dsel_n;
    logic       wdata_n;
    logic       write_gate;
    logic       drv_oe_n;
    logic       dir_n;
    logic       step_n;
    logic       head_n;
    logic [1:0] dens;
    logic       drive_power_off_out;
    logic       dchg_s1;
    logic       dchg_s2;
  } fap_ctl_t;

endpackage : fap_pkg

// *** logic/fap_timer_if.sv ***
// carrier between the controller and its idle timer
interface fap_timer_if;
  logic restart;
  logic expired;

  modport ctrl  (output restart, input  expired);
  modport timer (input  restart, output expired);
endinterface : fap_timer_if

// *** logic/fap_idle_timer.sv ***
// auto powerdown idle timer
`include "fap_params.svh"

module fap_idle_timer #(
  parameter logic [`FAP_TMR_W-1:0] CYCLES = `FAP_TMR_W'(`FAP_APD_CYCLES)
) (
  input wire logic     clk_in,
  input wire logic     resetn_in,
  fap_timer_if.timer   tmr
);

  fap_pkg::fap_tmr_t st;
  fap_pkg::fap_tmr_t next_st;

  // ==========================================================
  // counter
  always_comb begin
    next_st = st;
    if (tmr.restart) begin
      next_st.count   = '0;
      next_st.expired = 1'b0;
    end else if (!st.expired) begin
      next_st.count = st.count + `FAP_TMR_W'(1);
      if (st.count == CYCLES - `FAP_TMR_W'(1)) begin
        next_st.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tmr.expired = st.expired;

  // ==========================================================
  // checks
  a_timer_full_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(st.expired) |-> $past(st.count) == CYCLES - `FAP_TMR_W'(1))
    else $error("timer expired at wrong count");

  a_timer_restart_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tmr.restart |=> !st.expired && st.count == '0)
    else $error("timer not restarted");

endmodule : fap_idle_timer

// *** logic/fap_ctrl.sv ***
// floppy controller auto powerdown, register front end and drive pins
// Contract
// - auto powerdown only while enable bit set
// - all motor enable bits must be zero
// - status idle 80h and interrupt low
// - head unload timer must have expired
// - ten millisecond idle timer must run out
// - timer starts at enable; enter when all true
// - clearing enable cancels timer, blocks powerdown
// - rate register powerdown overrides auto mode; drive power off still follows auto pd while enabled
// - hardware or software reset wakes, resets
// - access wake keeps all state intact
// - motor enable write wakes; read does not
// - main status read wakes
// - data register read or write wakes
// - after wake, restart timer and retry
// - other registers served without waking
// - writes during powerdown stored, used later
// - access raises power only briefly
// - drive outputs disabled in powerdown
// - host bus stays active in powerdown
// - motor, select, write pins tristate; others driven
// - drive power: shutdown, else auto, else bit6
//
// Chosen here: register access over APB and the register addresses.
`include "fap_params.svh"

module fap_ctrl #(
  parameter logic [`FAP_TMR_W-1:0] APD_CYCLES = `FAP_TMR_W'(`FAP_APD_CYCLES)
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic [7:0]  MSR_IN,
  input  wire logic        CTRL_INT_IN,
  input  wire logic        HEAD_UNLOAD_DONE_IN,
  input  wire logic [7:0]  FIFO_RD_DATA_IN,
  input  wire logic        DISK_CHANGE_IN,
  input  wire logic        WRITE_DATA_N_IN,
  input  wire logic        WRITE_GATE_IN,
  input  wire logic        STEP_DIRECTION_N_IN,
  input  wire logic        STEP_PULSE_N_IN,
  input  wire logic        HEAD_SELECT_N_IN,
  input  wire logic [1:0]  DENSITY_SELECT_IN,
  output logic      [1:0]  MOTOR_ON_N_OUT,
  output logic      [1:0]  DRIVE_SELECT_N_OUT,
  output logic             WRITE_DATA_N_OUT,
  output logic             WRITE_GATE_OUT,
  output logic             DRIVE_OE_N_OUT,
  output logic             STEP_DIRECTION_N_OUT,
  output logic             STEP_PULSE_N_OUT,
  output logic             HEAD_SELECT_N_OUT,
  output logic      [1:0]  DENSITY_SELECT_OUT,
  output logic             DRIVE_POWER_OFF_OUT,
  output logic             CORE_POWER_DOWN_OUT,
  output logic             CORE_RESET_OUT,
  output logic             ACCESS_BOOST_OUT,
  output logic      [7:0]  DATA_WR_OUT,
  output logic             DATA_WR_STB_OUT,
  output logic             DATA_RD_STB_OUT,
  output logic      [1:0]  DATA_RATE_OUT
);

  fap_pkg::fap_ctl_t st;
  fap_pkg::fap_ctl_t next_st;
  fap_timer_if       tmr_if ();

  // ==========================================================
  // address decode, shared by setup and access phases
  function automatic logic [4:0] fap_decode(input logic [11:0] addr);
    logic [3:0] idx;
    logic       ok;
    idx = addr[5:2];
    ok  = 1'b0;
    if (addr[11:6] != 6'h00 || addr[1:0] != 2'h0) begin
      ok = 1'b0;
    end else if (idx == `FAP_IDX_SRA || idx == `FAP_IDX_SRB || idx == `FAP_IDX_DOR) begin
      ok = 1'b1;
    end else if (idx == `FAP_IDX_DSR || idx == `FAP_IDX_DATA || idx == `FAP_IDX_DIR) begin
      ok = 1'b1;
    end else if (idx == `FAP_IDX_APC || idx == `FAP_IDX_MODE || idx == `FAP_IDX_PSTAT) begin
      ok = 1'b1;
    end
    return {ok, idx};
  endfunction : fap_decode

  // ==========================================================
  // decode and events
  logic [4:0] dec_setup;
  logic [4:0] dec_acc;
  logic       setup;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] wbyte;
  logic       apd_en;
  logic       dor_wr;
  logic       dsr_wr;
  logic       motor_wake;
  logic       dor_rst;
  logic       dsr_rst;
  logic       msr_rd;
  logic       data_acc;
  logic       wake;
  logic       conds;
  logic       dsr_pd;
  logic       off;
  logic       will_wake;

  assign dec_setup = fap_decode(PADDR_IN);
  assign dec_acc   = fap_decode(PADDR_IN);
  assign setup     = PSEL_IN && !PENABLE_IN;
  // bus side keeps answering in powerdown so wake accesses are seen
  assign acc       = PSEL_IN && PENABLE_IN && st.pready && dec_acc[4];
  assign wr        = acc && PWRITE_IN;
  assign rd        = acc && !PWRITE_IN;
  assign wbyte     = PWDATA_IN[7:0];
  assign apd_en    = st.apc[`FAP_APC_EN_BIT];
  assign dsr_pd    = st.dsr[`FAP_DSR_PD_BIT];
  assign dor_wr    = wr && dec_acc[3:0] == `FAP_IDX_DOR;
  assign dsr_wr    = wr && dec_acc[3:0] == `FAP_IDX_DSR;
  assign motor_wake = dor_wr && wbyte[`FAP_DOR_MOT_HI:`FAP_DOR_MOT_LO] != 4'h0;
  assign dor_rst   = dor_wr && !wbyte[`FAP_DOR_NRST_BIT];
  assign dsr_rst   = dsr_wr && wbyte[`FAP_DSR_SWRST_BIT];
  assign msr_rd    = rd && dec_acc[3:0] == `FAP_IDX_DSR;
  assign data_acc  = acc && dec_acc[3:0] == `FAP_IDX_DATA;
  assign wake      = motor_wake || dor_rst || dsr_rst || msr_rd || data_acc;

  // same wake events seen from the setup cycle on, so the boost skips waking accesses
  assign will_wake = dec_acc[4] && ((dec_acc[3:0] == `FAP_IDX_DOR && PWRITE_IN
                       && (wbyte[`FAP_DOR_MOT_HI:`FAP_DOR_MOT_LO] != 4'h0
                       || !wbyte[`FAP_DOR_NRST_BIT]))
                   || (dec_acc[3:0] == `FAP_IDX_DSR
                       && (!PWRITE_IN || wbyte[`FAP_DSR_SWRST_BIT]))
                   || dec_acc[3:0] == `FAP_IDX_DATA);

  assign conds = st.digital_output_reg[`FAP_DOR_MOT_HI:`FAP_DOR_MOT_LO] == 4'h0
              && MSR_IN == `FAP_MSR_IDLE && !CTRL_INT_IN
              && HEAD_UNLOAD_DONE_IN
              && tmr_if.expired
              && !dsr_pd;

  // timer runs from enable and from every wake; held while disabled
  assign tmr_if.restart = !apd_en || wake || dsr_pd;
  assign off = st.pd || dsr_pd;

  fap_idle_timer #(
    .CYCLES (APD_CYCLES)
  ) u_timer (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .tmr       (tmr_if)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_st             = st;
    next_st.data_wr_stb = 1'b0;
    next_st.data_rd_stb = 1'b0;
    next_st.dchg_s1     = DISK_CHANGE_IN;
    next_st.dchg_s2     = st.dchg_s1;

    // apb answer: one access cycle after setup
    if (setup) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !dec_setup[4];
      next_st.prdata  = 8'h00;
      if (dec_setup[3:0] == `FAP_IDX_SRA) begin
        next_st.prdata = {CTRL_INT_IN, 7'h00};
      end else if (dec_setup[3:0] == `FAP_IDX_SRB) begin
        next_st.prdata = {2'h3, 4'h0, ~st.motor_n};
      end else if (dec_setup[3:0] == `FAP_IDX_DOR) begin
        next_st.prdata = st.digital_output_reg;
      end else if (dec_setup[3:0] == `FAP_IDX_DSR) begin
        next_st.prdata = MSR_IN;
      end else if (dec_setup[3:0] == `FAP_IDX_DATA) begin
        next_st.prdata = FIFO_RD_DATA_IN;
      end else if (dec_setup[3:0] == `FAP_IDX_DIR) begin
        next_st.prdata = {st.dchg_s2, 7'h00};
      end else if (dec_setup[3:0] == `FAP_IDX_APC) begin
        next_st.prdata = st.apc;
      end else if (dec_setup[3:0] == `FAP_IDX_MODE) begin
        next_st.prdata = st.mode;
      end else if (dec_setup[3:0] == `FAP_IDX_PSTAT) begin
        next_st.prdata = {5'h00, dsr_pd, tmr_if.expired, st.pd};
      end
    end else if (PSEL_IN && PENABLE_IN && st.pready) begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end

    // register writes are kept whether or not the part is down
    if (dor_wr) begin
      next_st.digital_output_reg = wbyte;
    end
    if (dsr_wr) begin
      next_st.dsr = wbyte;
      next_st.dsr[`FAP_DSR_SWRST_BIT] = 1'b0;
    end
    if (dsr_rst) begin
      next_st.dsr = `FAP_DSR_RESET;
    end
    if (wr && dec_acc[3:0] == `FAP_IDX_DIR) begin
      next_st.ccr = wbyte;
    end
    if (wr && dec_acc[3:0] == `FAP_IDX_APC) begin
      next_st.apc = wbyte;
    end
    if (wr && dec_acc[3:0] == `FAP_IDX_MODE) begin
      next_st.mode = wbyte;
    end
    if (data_acc) begin
      next_st.data_wr_stb = PWRITE_IN;
      next_st.data_rd_stb = !PWRITE_IN;
      if (PWRITE_IN) begin
        next_st.data_wr = wbyte;
      end
    end
    next_st.core_reset = !next_st.digital_output_reg[`FAP_DOR_NRST_BIT] || dsr_rst;

    // powerdown flag; access wake touches nothing else
    if (!apd_en) begin
      next_st.pd = 1'b0;
    end else if (wake) begin
      next_st.pd = 1'b0;
    end else if (conds) begin
      next_st.pd = 1'b1;
    end

    // short power raise for accesses that leave the part down
    next_st.boost = st.pd && PSEL_IN && !will_wake;

    // drive pins: write path, motor and select float when down
    next_st.drv_oe_n = off;
    next_st.motor_n  = off ? 2'h3 : ~st.digital_output_reg[`FAP_DOR_MOT_LO+1:`FAP_DOR_MOT_LO];
    next_st.dsel_n   = off ? 2'h3 : {~st.digital_output_reg[`FAP_DOR_DSEL_BIT], st.digital_output_reg[`FAP_DOR_DSEL_BIT]};
    next_st.wdata_n  = off ? 1'b1 : WRITE_DATA_N_IN;
    next_st.write_gate    = off ? 1'b0 : WRITE_GATE_IN;
    next_st.dir_n    = STEP_DIRECTION_N_IN;
    next_st.step_n   = STEP_PULSE_N_IN;
    next_st.head_n   = HEAD_SELECT_N_IN;
    next_st.dens     = DENSITY_SELECT_IN;

    if (st.mode[`FAP_MODE_SHUT_BIT]) begin
      next_st.drive_power_off_out = 1'b1;
    end else if (apd_en) begin
      next_st.drive_power_off_out = st.pd;
    end else begin
      next_st.drive_power_off_out = dsr_pd;
    end
  end

  // ==========================================================
  // state register; hardware reset also ends any powerdown
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      st            <= '0;
      st.digital_output_reg        <= `FAP_DOR_RESET;
      st.dsr        <= `FAP_DSR_RESET;
      st.ccr        <= `FAP_CCR_RESET;
      st.apc        <= `FAP_APC_RESET;
      st.mode       <= `FAP_MODE_RESET;
      st.core_reset <= 1'b1;
      st.motor_n    <= 2'h3;
      st.dsel_n     <= 2'h3;
      st.wdata_n    <= 1'b1;
      st.dir_n      <= 1'b1;
      st.step_n     <= 1'b1;
      st.head_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign PRDATA_OUT           = {24'h000000, st.prdata};
  assign PREADY_OUT           = st.pready;
  assign PSLVERR_OUT          = st.pslverr;
  assign MOTOR_ON_N_OUT       = st.motor_n;
  assign DRIVE_SELECT_N_OUT   = st.dsel_n;
  assign WRITE_DATA_N_OUT     = st.wdata_n;
  assign WRITE_GATE_OUT       = st.write_gate;
  assign DRIVE_OE_N_OUT       = st.drv_oe_n;
  assign STEP_DIRECTION_N_OUT = st.dir_n;
  assign STEP_PULSE_N_OUT     = st.step_n;
  assign HEAD_SELECT_N_OUT    = st.head_n;
  assign DENSITY_SELECT_OUT   = st.dens;
  assign DRIVE_POWER_OFF_OUT  = st.drive_power_off_out;
  assign CORE_POWER_DOWN_OUT  = st.pd;
  assign CORE_RESET_OUT       = st.core_reset;
  assign ACCESS_BOOST_OUT     = st.boost;
  assign DATA_WR_OUT          = st.data_wr;
  assign DATA_WR_STB_OUT      = st.data_wr_stb;
  assign DATA_RD_STB_OUT      = st.data_rd_stb;
  assign DATA_RATE_OUT        = st.ccr[1:0];

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_disabled_stays_up: assert property (!apd_en |=> !st.pd)
    else $error("powerdown while disabled");
  a_motors_block_pd: assert property ($rose(st.pd) |->
    $past(st.digital_output_reg[`FAP_DOR_MOT_HI:`FAP_DOR_MOT_LO]) == 4'h0)
    else $error("powerdown with motor on");
  a_idle_blocks_pd: assert property ($rose(st.pd) |->
    $past(MSR_IN) == `FAP_MSR_IDLE && !$past(CTRL_INT_IN))
    else $error("powerdown while busy");
  a_head_blocks_pd: assert property ($rose(st.pd) |-> $past(HEAD_UNLOAD_DONE_IN))
    else $error("powerdown before head unload");
  a_timer_blocks_pd: assert property ($rose(st.pd) |-> $past(tmr_if.expired))
    else $error("powerdown before timer");
  a_msr_read_wake: assert property (st.pd && msr_rd |=> !st.pd)
    else $error("status read did not wake");
  a_data_wake: assert property (st.pd && data_acc |=> !st.pd)
    else $error("data access did not wake");
  a_motor_wake: assert property (st.pd && motor_wake |=> !st.pd && st.digital_output_reg != 8'h00)
    else $error("motor write did not wake");
  a_pins_float: assert property (st.pd |=> DRIVE_OE_N_OUT && !WRITE_GATE_OUT
    && MOTOR_ON_N_OUT == 2'h3) else $error("drive pins active in powerdown");
  a_shutdown_fpd: assert property (st.mode[`FAP_MODE_SHUT_BIT] |=> DRIVE_POWER_OFF_OUT)
    else $error("drive power not off on shutdown");
  a_boost_up_quiet: assert property (!st.pd |=> !ACCESS_BOOST_OUT)
    else $error("boost while powered up");
  a_boost_no_wake: assert property (st.pd && will_wake |=> !ACCESS_BOOST_OUT)
    else $error("boost on a waking access");
  a_quiet_access: assert property (st.pd && apd_en && acc && !wake |=> st.pd)
    else $error("non-waking access left powerdown");
  a_dsr_blocks_pd: assert property ($rose(st.pd) |-> !$past(dsr_pd))
    else $error("auto powerdown under rate register powerdown");
  a_data_strobe: assert property (data_acc |=> DATA_WR_STB_OUT == $past(PWRITE_IN)
    && DATA_RD_STB_OUT == !$past(PWRITE_IN)) else $error("data strobe missing");
  a_live_pins: assert property (RESETN_IN |=>
    STEP_DIRECTION_N_OUT == $past(STEP_DIRECTION_N_IN)
    && HEAD_SELECT_N_OUT == $past(HEAD_SELECT_N_IN)) else $error("driven pins stale");

endmodule : fap_ctrl

// *** test/fap_core_model.sv ***
// stand-in for the floppy core: status, interrupt, head unload and drive signals
module fap_core_model (
  input  wire logic       clk_in,
  input  wire logic       busy_in,
  input  wire logic       irq_in,
  input  wire logic       unload_in,
  output logic      [7:0] msr_out,
  output logic            int_out,
  output logic            unload_done_out,
  output logic      [7:0] fifo_out,
  output logic            dchg_out,
  output logic      [7:0] drv_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt = 8'h00;

  // ==========================================================
  // status seen by the power logic
  assign msr_out         = busy_in ? 8'h10 : 8'h80;
  assign int_out         = irq_in;
  assign unload_done_out = unload_in;
  assign fifo_out        = 8'hA5;
  assign dchg_out        = 1'h1;

  // ==========================================================
  // drive signals change every cycle, so a stale or frozen copy shows
  always @(posedge clk_in) begin
    cnt <= cnt + 8'h01;
  end
  assign drv_out = cnt;
endmodule : fap_core_model

// *** test/testbench.sv ***
// self-checking bench for the floppy auto powerdown block
`include "fap_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int          APD    = 20;
  localparam logic [11:0] A_SRB  = {6'h00, `FAP_IDX_SRB, 2'h0};
  localparam logic [11:0] A_DOR  = {6'h00, `FAP_IDX_DOR, 2'h0};
  localparam logic [11:0] A_MSR  = {6'h00, `FAP_IDX_DSR, 2'h0};
  localparam logic [11:0] A_DAT  = {6'h00, `FAP_IDX_DATA, 2'h0};
  localparam logic [11:0] A_DIR  = {6'h00, `FAP_IDX_DIR, 2'h0};
  localparam logic [11:0] A_APC  = {6'h00, `FAP_IDX_APC, 2'h0};
  localparam logic [11:0] A_MODE = {6'h00, `FAP_IDX_MODE, 2'h0};
  localparam logic [11:0] A_PST  = {6'h00, `FAP_IDX_PSTAT, 2'h0};

  logic        clk     = 1'h0;
  logic        rst_n   = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        busy    = 1'h0;
  logic        irq     = 1'h0;
  logic        unload  = 1'h1;
  logic [31:0] prdata, rd;
  logic [7:0]  main_status_reg, fifo, drv, data_wr;
  logic [1:0]  mot_n, dens, rate, dsel_n;
  logic        pready, pslverr, cint, hud, dchg, oe_n, dir_n, step_n, head_n;
  logic        drive_power_off_out, pd, creset, boost, err, bst, wdat_n, write_gate, wstb, rstb;
  int          failures  = 0;
  int          cmp_count = 0;

  always #4 clk = ~clk;

  fap_core_model core (.clk_in(clk), .busy_in(busy), .irq_in(irq), .unload_in(unload),
    .msr_out(main_status_reg), .int_out(cint), .unload_done_out(hud), .fifo_out(fifo),
    .dchg_out(dchg), .drv_out(drv));

  fap_ctrl #(.APD_CYCLES(`FAP_TMR_W'(APD))) dut (.CLK_IN(clk), .RESETN_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .MSR_IN(main_status_reg), .CTRL_INT_IN(cint), .HEAD_UNLOAD_DONE_IN(hud), .FIFO_RD_DATA_IN(fifo),
    .DISK_CHANGE_IN(dchg), .WRITE_DATA_N_IN(drv[0]), .WRITE_GATE_IN(drv[1]),
    .STEP_DIRECTION_N_IN(drv[2]), .STEP_PULSE_N_IN(drv[3]), .HEAD_SELECT_N_IN(drv[4]),
    .DENSITY_SELECT_IN(drv[6:5]), .MOTOR_ON_N_OUT(mot_n), .DRIVE_SELECT_N_OUT(dsel_n),
    .WRITE_DATA_N_OUT(wdat_n), .WRITE_GATE_OUT(write_gate), .DRIVE_OE_N_OUT(oe_n),
    .STEP_DIRECTION_N_OUT(dir_n), .STEP_PULSE_N_OUT(step_n), .HEAD_SELECT_N_OUT(head_n),
    .DENSITY_SELECT_OUT(dens), .DRIVE_POWER_OFF_OUT(drive_power_off_out), .CORE_POWER_DOWN_OUT(pd),
    .CORE_RESET_OUT(creset), .ACCESS_BOOST_OUT(boost), .DATA_WR_OUT(data_wr),
    .DATA_WR_STB_OUT(wstb), .DATA_RD_STB_OUT(rstb), .DATA_RATE_OUT(rate));

  // ==========================================================
  // verdict
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // ==========================================================
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    bst = 1'h0;
    do begin
      @(posedge clk);
      bst = bst | boost;
      i++;
    end while (pready !== 1'h1 && i < 50);
    if (i >= 50) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 8'h00);
    chk(rd, exp);
  endtask : rdc

  // bounded wait; running out ends the run
  task automatic wait_pd();
    int i;
    i = 0;
    while (pd !== 1'h1 && i < 4 * APD) begin
      @(posedge clk);
      i++;
    end
    chk(pd, 1'h1);
    if (pd !== 1'h1) begin
      stop_test();
    end
  endtask : wait_pd

  // drive pins copy the core one cycle later; write pins idle while down
  task automatic pins(input logic down);
    logic [6:0] v;
    @(posedge clk);
    v = {drv[2], drv[3], drv[4], drv[6:5], (down ? 2'h2 : {drv[0], drv[1]})};
    @(posedge clk);
    chk({dir_n, step_n, head_n, dens, wdat_n, write_gate}, v);
  endtask : pins

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    rdc(A_PST, 32'h0);
    apb(1'h0, A_DIR, 8'h00);
    chk(rd & 32'h80, 32'h80);
    apb(1'h0, 12'h00C, 8'h00);
    chk(err, 1'h1);
    wr(A_DOR, 8'h04);
    cyc(3 * APD);
    chk(pd, 1'h0);
    $display("test reset and disabled done");
    wr(A_APC, 8'h01);
    cyc(APD - 2);
    chk(pd, 1'h0);
    wait_pd();
    cyc(2);
    chk(oe_n, 1'h1);
    chk(drive_power_off_out, 1'h1);
    pins(1'h1);
    chk(dsel_n, 2'h3);
    $display("test entry done");
    rdc(A_DOR, 32'h04);
    chk(bst, 1'h1);
    rdc(A_SRB, 32'hC0);
    apb(1'h0, A_PST, 8'h00);
    chk(rd & 32'h1, 32'h1);
    wr(A_DIR, 8'h01);
    cyc(2);
    chk(pd, 1'h1);
    chk(boost, 1'h0);
    rdc(A_MSR, 32'h80);
    cyc(2);
    chk(pd, 1'h0);
    cyc(1);
    chk(oe_n, 1'h0);
    chk(rate, 2'h1);
    pins(1'h0);
    chk(dsel_n, 2'h2);
    rdc(A_DOR, 32'h04);
    wait_pd();
    $display("test non-waking access done");
    apb(1'h0, A_DAT, 8'h00);
    chk(rd, 32'hA5);
    cyc(1);
    chk(rstb, 1'h1);
    cyc(1);
    chk(pd, 1'h0);
    wait_pd();
    wr(A_DAT, 8'h3C);
    cyc(1);
    chk(wstb, 1'h1);
    cyc(1);
    chk(pd, 1'h0);
    chk(data_wr, 8'h3C);
    wait_pd();
    wr(A_DOR, 8'h14);
    cyc(2);
    chk(pd, 1'h0);
    chk(mot_n, 2'h2);
    cyc(3 * APD);
    chk(pd, 1'h0);
    wr(A_DOR, 8'h04);
    wait_pd();
    $display("test data and motor done");
    for (int k = 0; k < 3; k++) begin
      rdc(A_MSR, 32'h80);
      busy   <= 1'(k == 0);
      irq    <= 1'(k == 1);
      unload <= 1'(k != 2);
      cyc(3 * APD);
      chk(pd, 1'h0);
      busy   <= 1'h0;
      irq    <= 1'h0;
      unload <= 1'h1;
      wait_pd();
    end
    $display("test idle conditions done");
    wr(A_MSR, 8'h82);
    cyc(2);
    chk(pd, 1'h0);
    wr(A_DOR, 8'h04);
    wait_pd();
    wr(A_DOR, 8'h00);
    cyc(2);
    chk(pd, 1'h0);
    chk(creset, 1'h1);
    wr(A_DOR, 8'h04);
    wait_pd();
    $display("test software reset done");
    wr(A_APC, 8'h00);
    cyc(2);
    chk(pd, 1'h0);
    chk(drive_power_off_out, 1'h0);
    cyc(3 * APD);
    chk(pd, 1'h0);
    wr(A_MODE, 8'h20);
    cyc(2);
    chk(drive_power_off_out, 1'h1);
    wr(A_MODE, 8'h00);
    wr(A_MSR, 8'h42);
    cyc(2);
    chk(drive_power_off_out, 1'h1);
    chk(oe_n, 1'h1);
    wr(A_APC, 8'h01);
    cyc(3 * APD);
    chk(pd, 1'h0);
    wr(A_MSR, 8'h02);
    wait_pd();
    $display("test disable and override done");
    rst_n <= 1'h0;
    cyc(2);
    chk(pd, 1'h0);
    chk(rate, 2'h2);
    chk(creset, 1'h1);
    rst_n <= 1'h1;
    $display("test hardware reset done");
    stop_test();
  end
endmodule : testbench
